// ### verilog/bsa_pkg.sv
// constants and types shared by the sixteen bit slice datapath
package bsa_pkg;
  localparam int          DW          = 16;
  localparam int          SW          = 4;
  localparam int          NSL         = 4;
  localparam int          AW          = 4;
  localparam int          IW          = 8;
  localparam int          CW          = 17;
  // timing: core clock period and one datapath cycle
  localparam int          CLK_NS      = 8;
  localparam int          CYCLE_NS    = 375;
  localparam int          LOW_NS      = 80;
  localparam int          CYCLE_CYC   = CYCLE_NS / CLK_NS;
  localparam int          LOW_CYC     = (LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int          HIGH_CYC    = CYCLE_CYC - LOW_CYC;
  localparam logic [5:0]  CNT_FALL    = 6'(HIGH_CYC - 1);
  localparam logic [5:0]  CNT_LAST    = 6'(CYCLE_CYC - 1);
  localparam logic [5:0]  CNT_RST     = 6'h00;
  // instruction field positions
  localparam int          I_SRC       = 0;
  localparam int          I_MOD       = 2;
  localparam int          I_FN        = 4;
  localparam int          I_DST       = 6;
  // control line positions
  localparam int          C_ASEL      = 0;
  localparam int          C_BSEL      = 1;
  localparam int          C_AMOD      = 2;
  localparam int          C_BMOD      = 4;
  localparam int          C_FN        = 6;
  localparam int          C_OSEL      = 8;
  localparam int          C_SHL       = 10;
  localparam int          C_SHR       = 11;
  localparam int          C_RWE       = 12;
  localparam int          C_QLD       = 13;
  localparam int          C_QSH       = 14;
  localparam int          C_SHOE      = 15;
  localparam int          C_ARITH     = 16;
  // operand stage codes
  localparam logic [1:0]  MOD_ZERO    = 2'h0;
  localparam logic [1:0]  MOD_ONE     = 2'h1;
  localparam logic [1:0]  MOD_TRUE    = 2'h2;
  localparam logic [1:0]  MOD_COMP    = 2'h3;
  // alu functions
  localparam logic [1:0]  FN_ADD      = 2'h0;
  localparam logic [1:0]  FN_AND      = 2'h1;
  localparam logic [1:0]  FN_OR       = 2'h2;
  localparam logic [1:0]  FN_XOR      = 2'h3;
  // output select
  localparam logic [1:0]  OSEL_ALU    = 2'h0;
  localparam logic [1:0]  OSEL_A      = 2'h1;
  localparam logic [1:0]  OSEL_B      = 2'h2;
  // destination codes
  localparam logic [1:0]  DST_RAM     = 2'h0;
  localparam logic [1:0]  DST_SHL     = 2'h1;
  localparam logic [1:0]  DST_SHR     = 2'h2;
  localparam logic [1:0]  DST_Q       = 2'h3;
  typedef enum logic [0:0] {
    PH_HIGH = 1'b0,
    PH_LOW  = 1'b1
  } bsa_phase_e;
endpackage

// ### verilog/bsa_regfile.sv
// sixteen word two port register file of one slice, registered reads
`timescale 1ns/1ps
module bsa_regfile
  import bsa_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr_a,
  input  wire logic [AW-1:0] addr_b,
  input  wire logic [SW-1:0] wdata,
  output logic      [SW-1:0] rdata_a_q,
  output logic      [SW-1:0] rdata_b_q
);
  logic [SW-1:0] mem [0:(1<<AW)-1];

  // port a has no write path; all writes go through port b
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr_b] <= wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    rdata_a_q <= mem[addr_a];
    rdata_b_q <= mem[addr_b];
  end
endmodule // bsa_regfile

// ### verilog/bsa_lookahead.sv
// carry look-ahead generator joining four slices
`timescale 1ns/1ps
module bsa_lookahead
  import bsa_pkg::*;
(
  input  wire logic [NSL-1:0] gen,
  input  wire logic [NSL-1:0] prop,
  input  wire logic           cin,
  output logic      [NSL:0]   carry
);
  always_comb begin
    carry[0] = cin;
    for (int k = 0; k < NSL; k++) begin
      carry[k+1] = gen[k] | (prop[k] & carry[k]);
    end
  end
endmodule // bsa_lookahead

// ### verilog/bsa_datapath.sv
// sixteen bit datapath of four four-bit slices with look-ahead carry
// Operation
// RULE_01 - sixteen bits from four slices plus look-ahead
// RULE_02 - controller drives instruction and register addresses
// RULE_03 - eight instruction lines decode to 17 controls
// RULE_04 - sixteen by four file, two simultaneous reads
// RULE_05 - port a read only, writes via port b
// RULE_06 - file written during low phase only
// RULE_07 - read latches transparent high, hold from fall
// RULE_08 - operand a data or a latch; b latch or q
// RULE_09 - each operand zero, one, true or complement; the decode gives a zero, true or complement and b true or complement only
// RULE_10 - overflow plus high and low zero detects
// RULE_11 - output mux picks alu, a latch, b latch
// RULE_12 - outputs drive only while enable low
// RULE_13 - ram shifter passes or shifts one bit
// RULE_14 - q loads alu result or shifts itself
// RULE_15 - two-way shift pins at both ends
// RULE_16 - q and ram shift same direction together
// RULE_17 - wire ram lsb out to q msb in
// RULE_18 - q master low phase, slave at rise
// RULE_19 - slices give generate and propagate outputs
// RULE_20 - one operation within a 375 ns cycle
`timescale 1ns/1ps
module bsa_datapath
  import bsa_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           rst,
  input  wire logic [IW-1:0]  slice_instruction_inputs,
  input  wire logic [AW-1:0]  addr_a,
  input  wire logic [AW-1:0]  addr_b,
  input  wire logic [DW-1:0]  data_in,
  input  wire logic           carry_in,
  input  wire logic           clk_hold_high,
  input  wire logic           out_en_n,
  input  wire logic           ram_lsb_i,
  output logic                ram_lsb_o,
  output logic                ram_lsb_oe,
  input  wire logic           ram_msb_i,
  output logic                ram_msb_o,
  output logic                ram_msb_oe,
  input  wire logic           q_lsb_i,
  output logic                q_lsb_o,
  output logic                q_lsb_oe,
  input  wire logic           q_msb_i,
  output logic                q_msb_o,
  output logic                q_msb_oe,
  output logic      [DW-1:0]  data_out,
  output logic      [DW-1:0]  data_oe,
  output logic                overflow,
  output logic                zero,
  output logic                zero_n,
  output logic                carry_out,
  output logic      [NSL-1:0] slice_gen,
  output logic      [NSL-1:0] slice_prop,
  output logic                phase_low
);
  // instruction rom: eight lines in, seventeen control lines out
  function automatic logic [CW-1:0] bsa_decode(input logic [IW-1:0] ins);
    logic [CW-1:0] c;
    logic [1:0]    md;
    logic [1:0]    dst;
    c   = '0;
    md  = ins[I_MOD +: 2];
    dst = ins[I_DST +: 2];
    c[C_ASEL] = ins[I_SRC + 1];
    c[C_BSEL] = ins[I_SRC];
    unique case (md)
      2'h0: begin
        c[C_AMOD +: 2] = MOD_TRUE;
        c[C_BMOD +: 2] = MOD_TRUE;
      end
      2'h1: begin
        c[C_AMOD +: 2] = MOD_COMP;
        c[C_BMOD +: 2] = MOD_TRUE;
      end
      2'h2: begin
        c[C_AMOD +: 2] = MOD_TRUE;
        c[C_BMOD +: 2] = MOD_COMP;
      end
      2'h3: begin
        c[C_AMOD +: 2] = MOD_ZERO;
        c[C_BMOD +: 2] = MOD_TRUE;
      end
    endcase
    c[C_FN +: 2] = ins[I_FN +: 2];
    c[C_ARITH]   = (ins[I_FN +: 2] == FN_ADD);
    unique case (dst)
      DST_RAM: begin
        c[C_RWE]      = 1'b1;
        c[C_OSEL +: 2] = OSEL_ALU;
      end
      DST_SHL: begin
        c[C_RWE]      = 1'b1;
        c[C_QSH]      = 1'b1;
        c[C_SHL]      = 1'b1;
        c[C_SHOE]     = 1'b1;
        c[C_OSEL +: 2] = OSEL_A;
      end
      DST_SHR: begin
        c[C_RWE]      = 1'b1;
        c[C_QSH]      = 1'b1;
        c[C_SHR]      = 1'b1;
        c[C_SHOE]     = 1'b1;
        c[C_OSEL +: 2] = OSEL_A;
      end
      DST_Q: begin
        c[C_QLD]      = 1'b1;
        c[C_OSEL +: 2] = OSEL_B;
      end
    endcase
    return c;
  endfunction

  // zero, one, true or complement stage in front of the alu
  function automatic logic [DW-1:0] bsa_stage(input logic [1:0]    md,
                                              input logic [DW-1:0] v);
    logic [DW-1:0] r;
    r = '0;
    unique case (md)
      MOD_ZERO: r = '0;
      MOD_ONE:  r = '1;
      MOD_TRUE: r = v;
      MOD_COMP: r = ~v;
    endcase
    return r;
  endfunction

  bsa_phase_e    phase_q;
  logic [5:0]    cnt_q;
  logic          fall_evt;
  logic          rise_evt;
  logic [CW-1:0] ctl;
  logic [DW-1:0] rd_a;
  logic [DW-1:0] rd_b;
  logic [DW-1:0] lat_a_q;
  logic [DW-1:0] lat_b_q;
  logic [DW-1:0] lat_a;
  logic [DW-1:0] lat_b;
  logic [DW-1:0] q_master_q;
  logic [DW-1:0] q_q;
  logic [DW-1:0] opa;
  logic [DW-1:0] opb;
  logic [DW-1:0] alu_f;
  logic [DW:0]   cbit;
  logic [NSL:0]  cslice;
  logic [NSL-1:0] g_sl;
  logic [NSL-1:0] p_sl;
  logic [DW-1:0] ram_d;
  logic [DW-1:0] q_d;
  logic [DW-1:0] out_mux;
  logic          ram_we;

  assign ctl = bsa_decode(slice_instruction_inputs); // see RULE_03

  // cycle divider: high phase then low phase; hold keeps it high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q   <= CNT_RST;
      phase_q <= PH_HIGH;
    end else if (clk_hold_high && phase_q == PH_HIGH) begin
      cnt_q   <= CNT_RST; // see RULE_06
    end else if (cnt_q == CNT_LAST) begin
      cnt_q   <= CNT_RST; // see RULE_20
      phase_q <= PH_HIGH;
    end else begin
      cnt_q   <= cnt_q + 6'h01;
      if (fall_evt) begin
        phase_q <= PH_LOW;
      end
    end
  end

  assign fall_evt = (phase_q == PH_HIGH) && !clk_hold_high &&
                    (cnt_q == CNT_FALL);
  // commit only at the end of a real low phase
  assign rise_evt = (phase_q == PH_LOW) && (cnt_q == CNT_LAST);
  assign ram_we   = rise_evt && ctl[C_RWE]; // see RULE_06

  // one register file per slice, built by the generate loop
  genvar s;
  generate
    for (s = 0; s < NSL; s++) begin : g_slice
      logic [SW-1:0] a4;
      logic [SW-1:0] b4;
      logic [SW-1:0] gb;
      logic [SW-1:0] pb;
      logic [SW-1:0] cc;

      bsa_regfile u_rf (
        .core_clk  (core_clk),
        .we        (ram_we),
        .addr_a    (addr_a),
        .addr_b    (addr_b),
        .wdata     (ram_d[s*SW +: SW]),
        .rdata_a_q (rd_a[s*SW +: SW]),
        .rdata_b_q (rd_b[s*SW +: SW])
      ); // see RULE_04 see RULE_05

      assign a4 = opa[s*SW +: SW];
      assign b4 = opb[s*SW +: SW];
      assign gb = a4 & b4;
      assign pb = a4 | b4;

      // ripple inside the slice, look-ahead between slices
      // local carries keep each slice the only driver of its bits
      always_comb begin
        cc[0] = cslice[s];
        for (int k = 0; k < SW - 1; k++) begin
          cc[k+1] = gb[k] | (pb[k] & cc[k]);
        end
      end

      assign cbit[s*SW +: SW] = cc;

      assign g_sl[s] = gb[3] | (pb[3] & gb[2]) | (pb[3] & pb[2] & gb[1])
                     | (pb[3] & pb[2] & pb[1] & gb[0]); // see RULE_19
      assign p_sl[s] = &pb; // see RULE_19
    end
  endgenerate

  bsa_lookahead u_cla (
    .gen   (g_sl),
    .prop  (p_sl),
    .cin   (carry_in),
    .carry (cslice)
  ); // see RULE_01

  assign cbit[DW] = cslice[NSL];

  // transparent while high, frozen from the falling edge
  assign lat_a = (phase_q == PH_HIGH) ? rd_a : lat_a_q; // see RULE_07
  assign lat_b = (phase_q == PH_HIGH) ? rd_b : lat_b_q; // see RULE_07

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lat_a_q <= '0;
      lat_b_q <= '0;
    end else if (phase_q == PH_HIGH) begin
      lat_a_q <= rd_a; // see RULE_07
      lat_b_q <= rd_b;
    end
  end

  // operand selection and the symmetric input stages
  always_comb begin
    opa = bsa_stage(ctl[C_AMOD +: 2],
                    ctl[C_ASEL] ? data_in : lat_a); // see RULE_08 see RULE_09
    opb = bsa_stage(ctl[C_BMOD +: 2],
                    ctl[C_BSEL] ? q_q : lat_b); // see RULE_08 see RULE_09
  end

  always_comb begin
    alu_f = '0;
    unique case (ctl[C_FN +: 2])
      FN_ADD: alu_f = opa ^ opb ^ cbit[DW-1:0]; // see RULE_01
      FN_AND: alu_f = opa & opb;
      FN_OR:  alu_f = opa | opb;
      FN_XOR: alu_f = opa ^ opb;
    endcase
  end

  // ram shifter: pass, or one place with the pin feeding the end
  always_comb begin
    ram_d = alu_f;
    if (ctl[C_SHL]) begin
      ram_d = {alu_f[DW-2:0], ram_lsb_i}; // see RULE_13 see RULE_15
    end else if (ctl[C_SHR]) begin
      ram_d = {ram_msb_i, alu_f[DW-1:1]}; // see RULE_13 see RULE_15
    end
  end

  // q shifter shares the ram shift controls
  always_comb begin
    q_d = q_q;
    if (ctl[C_QLD]) begin
      q_d = alu_f; // see RULE_14
    end else if (ctl[C_QSH] && ctl[C_SHL]) begin
      q_d = {q_q[DW-2:0], q_lsb_i}; // see RULE_14 see RULE_16
    end else if (ctl[C_QSH] && ctl[C_SHR]) begin
      q_d = {q_msb_i, q_q[DW-1:1]}; // see RULE_14 see RULE_16
    end
  end

  // master follows during low, slave takes it at the rise
  always_ff @(posedge core_clk) begin
    if (rst) begin
      q_master_q <= '0;
      q_q        <= '0;
    end else begin
      if (phase_q == PH_LOW) begin
        q_master_q <= q_d; // see RULE_18
      end
      if (rise_evt) begin
        q_q <= q_master_q; // see RULE_18
      end
    end
  end

  always_comb begin
    out_mux = alu_f;
    unique case (ctl[C_OSEL +: 2])
      OSEL_ALU: out_mux = alu_f; // see RULE_11
      OSEL_A:   out_mux = lat_a; // see RULE_11
      OSEL_B:   out_mux = lat_b; // see RULE_11
      default:  out_mux = alu_f;
    endcase
  end

  // registered pins; one cycle later than the internal buses
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_out <= '0;
      data_oe  <= '0;
    end else begin
      data_out <= out_mux;
      data_oe  <= {DW{!out_en_n}}; // see RULE_12
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      overflow  <= 1'b0;
      zero      <= 1'b0;
      zero_n    <= 1'b1;
      carry_out <= 1'b0;
      slice_gen <= '0;
      slice_prop <= '0;
      phase_low <= 1'b0;
    end else begin
      overflow  <= ctl[C_ARITH] & (cbit[DW] ^ cbit[DW-1]); // see RULE_10
      zero      <= (alu_f == '0); // see RULE_10
      zero_n    <= (alu_f != '0); // see RULE_10
      carry_out <= cslice[NSL];
      slice_gen <= g_sl; // see RULE_19
      slice_prop <= p_sl;
      phase_low <= (phase_q == PH_LOW);
    end
  end

  // shift pins: the end that shifts out drives, the other listens
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ram_lsb_o  <= 1'b0;
      ram_lsb_oe <= 1'b0;
      ram_msb_o  <= 1'b0;
      ram_msb_oe <= 1'b0;
      q_lsb_o    <= 1'b0;
      q_lsb_oe   <= 1'b0;
      q_msb_o    <= 1'b0;
      q_msb_oe   <= 1'b0;
    end else begin
      ram_msb_o  <= alu_f[DW-1];
      ram_msb_oe <= ctl[C_SHOE] & ctl[C_SHL]; // see RULE_15
      ram_lsb_o  <= alu_f[0]; // see RULE_17
      ram_lsb_oe <= ctl[C_SHOE] & ctl[C_SHR]; // see RULE_15
      q_msb_o    <= q_q[DW-1];
      q_msb_oe   <= ctl[C_SHOE] & ctl[C_SHL]; // see RULE_16
      q_lsb_o    <= q_q[0];
      q_lsb_oe   <= ctl[C_SHOE] & ctl[C_SHR]; // see RULE_16
    end
  end
endmodule // bsa_datapath

// ### dv/bsa_datapath_sva.sv
// checker for the sixteen bit slice datapath ports
`timescale 1ns/1ps
module bsa_datapath_sva
  import bsa_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          rst,
  input wire logic [IW-1:0] slice_instruction_inputs,
  input wire logic          clk_hold_high,
  input wire logic          out_en_n,
  input wire logic          ram_lsb_oe,
  input wire logic          ram_msb_oe,
  input wire logic          q_lsb_oe,
  input wire logic          q_msb_oe,
  input wire logic [DW-1:0] data_out,
  input wire logic [DW-1:0] data_oe,
  input wire logic          zero,
  input wire logic          zero_n,
  input wire logic          phase_low
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [1:0] dst;
  logic [6:0] hold_cnt_q;
  assign dst = slice_instruction_inputs[7:6];
  // saturating count of cycles the clock is frozen high
  always_ff @(posedge core_clk) begin
    if (rst || !clk_hold_high) hold_cnt_q <= 7'h00;
    else if (hold_cnt_q != 7'h7f) hold_cnt_q <= hold_cnt_q + 7'h01;
  end
  property p_zero_pair; zero_n != zero; endproperty
  a_zero_pair: assert property (p_zero_pair) else $error("zero pair");
  property p_zero_out; dst == DST_RAM |=> zero == (data_out == 16'h0000);
  endproperty
  a_zero_out: assert property (p_zero_out) else $error("zero vs out");
  property p_oe; 1'b1 |=> data_oe == {DW{!$past(out_en_n)}}; endproperty
  a_oe: assert property (p_oe) else $error("output enable");
  property p_low_len;
    $rose(phase_low) |-> phase_low[*8] ##1 phase_low[*2] ##1 !phase_low;
  endproperty
  a_low_len: assert property (p_low_len) else $error("low phase");
  // 60 cycles covers the longest remaining cycle before the freeze bites
  property p_hold_stops; hold_cnt_q >= 7'h3c |-> !phase_low; endproperty
  a_hold_stops: assert property (p_hold_stops) else $error("hold");
  property p_same_dir;
    ram_msb_oe == q_msb_oe && ram_lsb_oe == q_lsb_oe;
  endproperty
  a_same_dir: assert property (p_same_dir) else $error("shift dir");
  property p_shl_oe; dst == DST_SHL |=> ram_msb_oe && !ram_lsb_oe; endproperty
  a_shl_oe: assert property (p_shl_oe) else $error("left pins");
  property p_shr_oe; dst == DST_SHR |=> ram_lsb_oe && !ram_msb_oe; endproperty
  a_shr_oe: assert property (p_shr_oe) else $error("right pins");
  property p_no_shift;
    dst == DST_RAM || dst == DST_Q |=> !ram_lsb_oe && !ram_msb_oe;
  endproperty
  a_no_shift: assert property (p_no_shift) else $error("idle pins");
  c_shl: cover property (dst == DST_SHL ##1 ram_msb_oe);
  c_hold: cover property (hold_cnt_q == 7'h3c);
  c_zero: cover property (zero && dst == DST_Q);
endmodule // bsa_datapath_sva

// ### dv/bsa_mprog_model.sv
// microprogram board model splitting the microword into fields
`timescale 1ns/1ps
module bsa_mprog_model
  import bsa_pkg::*;
(
  input  wire logic [15:0]   microword_field,
  output logic      [IW-1:0] slice_instruction_inputs,
  output logic      [AW-1:0] addr_a,
  output logic      [AW-1:0] addr_b
);
  // instruction straight from bits 7:0, no decode on the board
  assign slice_instruction_inputs = microword_field[7:0];
  assign addr_a = microword_field[11:8];
  assign addr_b = microword_field[15:12];
endmodule // bsa_mprog_model

// ### dv/bsa_datapath_tb.sv
// self-checking bench for the sixteen bit slice datapath
`timescale 1ns/1ps
module bsa_datapath_tb;
  import bsa_pkg::*;
  logic           core_clk = 1'b0;
  logic           rst = 1'b1;
  logic [15:0]    mw = 16'h0000;
  logic [DW-1:0]  data_in = 16'h0000;
  logic           carry_in = 1'b0;
  logic           clk_hold_high = 1'b0;
  logic           out_en_n = 1'b0;
  logic [IW-1:0]  ins;
  logic [AW-1:0]  addr_a, addr_b;
  logic           ram_lsb_o, ram_lsb_oe, ram_msb_o, ram_msb_oe;
  logic           q_lsb_o, q_lsb_oe, q_msb_o, q_msb_oe;
  logic           lsb_net, msb_net, overflow, zero, zero_n;
  logic           carry_out, phase_low;
  logic [DW-1:0]  data_out, data_oe, seen;
  logic [NSL-1:0] slice_gen, slice_prop;
  logic [3:0]     sf;
  logic [7:0]     sp;
  int             err_total = 0;
  int             checked = 0;

  always #4 core_clk = ~core_clk;
  // ram lsb tied to q msb, ram msb to q lsb; pulled low when idle
  assign lsb_net = ram_lsb_oe ? ram_lsb_o : (q_msb_oe & q_msb_o);
  assign msb_net = ram_msb_oe ? ram_msb_o : (q_lsb_oe & q_lsb_o);

  bsa_mprog_model i_bsa_mprog_model (.microword_field(mw),
    .slice_instruction_inputs(ins), .addr_a(addr_a), .addr_b(addr_b));
  bsa_datapath i_bsa_datapath (.core_clk(core_clk), .rst(rst),
    .slice_instruction_inputs(ins), .addr_a(addr_a), .addr_b(addr_b),
    .data_in(data_in), .carry_in(carry_in), .clk_hold_high(clk_hold_high),
    .out_en_n(out_en_n), .ram_lsb_i(lsb_net), .ram_lsb_o(ram_lsb_o),
    .ram_lsb_oe(ram_lsb_oe), .ram_msb_i(msb_net), .ram_msb_o(ram_msb_o),
    .ram_msb_oe(ram_msb_oe), .q_lsb_i(msb_net), .q_lsb_o(q_lsb_o),
    .q_lsb_oe(q_lsb_oe), .q_msb_i(lsb_net), .q_msb_o(q_msb_o),
    .q_msb_oe(q_msb_oe), .data_out(data_out), .data_oe(data_oe),
    .overflow(overflow), .zero(zero), .zero_n(zero_n),
    .carry_out(carry_out), .slice_gen(slice_gen), .slice_prop(slice_prop),
    .phase_low(phase_low));

  task automatic chk(input string what, input logic [15:0] exp, got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  // one instruction held for a whole datapath cycle
  task automatic op(input logic [7:0] i, input logic [3:0] a, b,
                    input logic [15:0] d);
    int n;
    n = 0;
    mw = {b, a, i};
    data_in = d;
    step(4);
    seen = data_out;
    sf = {overflow, zero, zero_n, carry_out};
    sp = {ram_msb_oe, ram_lsb_oe, q_msb_oe, q_lsb_oe, ram_msb_oe & ram_msb_o,
          ram_lsb_oe & ram_lsb_o, q_msb_oe & q_msb_o, q_lsb_oe & q_lsb_o};
    while (phase_low !== 1'b1 && n < 100) begin step(1); n++; end
    while (phase_low !== 1'b0 && n < 100) begin step(1); n++; end
    // an op right after a restart also spans the edge leaving it
    chk("cycle_end", 16'h0001, 16'(n + 4 <= CYCLE_CYC + 1));
  endtask

  // plain read: zero a operand, true b operand, b word written back
  task automatic rd(input logic [3:0] r, input logic [15:0] exp);
    op(8'h0c, 4'h0, r, 16'h0000);
    chk("read_back", exp, seen);
  endtask

  task automatic s_regs;
    op(8'h03, 4'h0, 4'h5, 16'h1234);
    chk("alu_out", 16'h1234, seen);
    op(8'h03, 4'h5, 4'h6, 16'habcd);
    op(8'h01, 4'h5, 4'hf, 16'h0000);
    chk("port_a", 16'h1234, seen);
    rd(4'h6, 16'habcd);
    chk("oe_on", 16'hffff, data_oe);
    out_en_n = 1'b1;
    step(2);
    chk("oe_off", 16'h0000, data_oe);
    out_en_n = 1'b0;
  endtask

  task automatic s_hold;
    clk_hold_high = 1'b1;
    mw = 16'h5003;
    data_in = 16'hffff;
    step(60);
    chk("hold_out", 16'hffff, data_out);
    chk("hold_phase", 16'h0000, 16'(phase_low));
    mw = 16'h00cd;
    step(2);
    clk_hold_high = 1'b0;
    op(8'hcd, 4'h0, 4'h0, 16'h0000);
    rd(4'h5, 16'h1234);
  endtask

  task automatic s_flags;
    carry_in = 1'b1;
    op(8'hca, 4'h0, 4'h5, 16'h1234);
    chk("sub_out", 16'h1234, seen);
    chk("sub_flags", 16'h0005, 16'(sf));
    chk("gen_prop", 16'h000f, 16'({slice_gen, slice_prop}));
    carry_in = 1'b0;
    op(8'hc3, 4'h0, 4'h0, 16'h0001);
    chk("one_flags", 16'h0002, 16'(sf));
    op(8'hc3, 4'h0, 4'h0, 16'h7fff);
    chk("ovf_flags", 16'h000a, 16'(sf));
  endtask

  task automatic s_shift;
    op(8'h4c, 4'h5, 4'h5, 16'h0000);
    chk("shl_pins", 16'h00a2, 16'(sp));
    chk("out_a", 16'h1234, seen);
    rd(4'h5, 16'h2469);
    op(8'h8c, 4'h0, 4'h5, 16'h0000);
    chk("shr_pins", 16'h0054, 16'(sp));
    rd(4'h5, 16'h1234);
    op(8'h0d, 4'h0, 4'hf, 16'h0000);
    chk("q_value", 16'h8000, seen);
  endtask

  // logic functions and the complemented a stage, q holds 8000
  task automatic s_logic;
    op(8'h13, 4'h0, 4'he, 16'hffff);
    chk("and_out", 16'h8000, seen);
    op(8'h23, 4'h0, 4'he, 16'h1234);
    chk("or_out", 16'h9234, seen);
    op(8'h33, 4'h0, 4'he, 16'hffff);
    chk("xor_out", 16'h7fff, seen);
    op(8'h07, 4'h0, 4'he, 16'h0001);
    chk("comp_a", 16'h7ffe, seen);
  endtask

  initial begin
    step(5);
    chk("rst_oe", 16'h0000, data_oe);
    chk("rst_zero_n", 16'h0001, 16'(zero_n));
    step(1);
    rst = 1'b0;
    s_regs();
    s_hold();
    s_flags();
    s_shift();
    s_logic();
    wrap_up();
  end

  initial begin
    #160000;
    err_total++;
    wrap_up();
  end
endmodule // bsa_datapath_tb

bind bsa_datapath bsa_datapath_sva i_bsa_datapath_sva (
  .core_clk(core_clk), .rst(rst),
  .slice_instruction_inputs(slice_instruction_inputs),
  .clk_hold_high(clk_hold_high), .out_en_n(out_en_n),
  .ram_lsb_oe(ram_lsb_oe), .ram_msb_oe(ram_msb_oe),
  .q_lsb_oe(q_lsb_oe), .q_msb_oe(q_msb_oe), .data_out(data_out),
  .data_oe(data_oe), .zero(zero), .zero_n(zero_n), .phase_low(phase_low));
